/* File: pdr_conv_model.sv */
// Purpose: converter model that hands stage results to the block
// Assumes: one result per call, optional idle gap after it
// Notes:   released bus shows inverted content so stale data cannot pass
`timescale 1ns/1ps
module pdr_conv_model (
  // clock
  input wire logic             CLOCK,
  // result stream
  output pdr_pkg::pdr_result_t RESULT
);
  pdr_pkg::pdr_result_t res_r = '0;
  assign RESULT = res_r;
  task automatic send(input logic [2:0] stage, input logic [15:0] data, input int gap);
    @(posedge CLOCK);
    res_r <= '{valid: 1'b1, stage: stage, data: data};
    @(posedge CLOCK);
    res_r <= '{valid: 1'b0, stage: ~stage, data: ~data};
    repeat (gap) @(posedge CLOCK);
    #1;
  endtask : send
endmodule : pdr_conv_model

/* File: pdr_pkg.sv */
// Purpose: shared constants and types for the proximity detect and recalibration block
// Assumes: 16-bit converter codes, eight conversion stages
// Notes:   register offsets are word indices; byte address is four times the index
package pdr_pkg;

  localparam int unsigned NUM_STAGES = 8;
  localparam int unsigned STAGE_W    = 3;
  localparam int unsigned CODE_W     = 16;
  localparam int unsigned REG_W      = 16;
  localparam int unsigned FAST_DEPTH = 4;
  localparam int unsigned SLOW_DEPTH = 2;

  // register word indices
  localparam logic [9:0] IDX_HOLD_SKIP = 10'h002;
  localparam logic [9:0] IDX_LEVELS    = 10'h003;
  localparam logic [9:0] IDX_TIMEOUTS  = 10'h004;
  localparam logic [9:0] IDX_CONTROL   = 10'h008;
  localparam logic [9:0] IDX_STATUS    = 10'h009;
  localparam logic [9:0] IDX_IRQ_STAT  = 10'h00a;
  localparam logic [9:0] IDX_IRQ_MASK  = 10'h00b;

  // field positions
  localparam int unsigned SKIP_LSB   = 0;
  localparam int unsigned FPHOLD_LSB = 4;
  localparam int unsigned LPHOLD_LSB = 8;
  localparam int unsigned HOVER_LSB  = 0;
  localparam int unsigned APPR_LSB   = 8;
  localparam int unsigned FPTMO_LSB  = 0;
  localparam int unsigned LPTMO_LSB  = 10;
  localparam int unsigned LOWPWR_BIT = 0;
  localparam int unsigned AMBLVL_LSB = 8;

  // reset values
  localparam logic [15:0] RST_HOLD_SKIP = 16'h0000;
  localparam logic [15:0] RST_LEVELS    = 16'h0000;
  localparam logic [15:0] RST_TIMEOUTS  = 16'h0000;
  localparam logic [15:0] RST_CONTROL   = 16'h0000;
  localparam logic [2:0]  RST_IRQ       = 3'h0;

  // interrupt bit positions
  localparam int unsigned IRQ_PROX   = 0;
  localparam int unsigned IRQ_RECAL  = 1;
  localparam int unsigned IRQ_EXPIRE = 2;
  localparam int unsigned IRQ_W      = 3;

  // one converter result for one stage
  typedef struct packed {
    logic               valid;
    logic [STAGE_W-1:0] stage;
    logic [CODE_W-1:0]  data;
  } pdr_result_t;

endpackage : pdr_pkg

/* File: pdr_prox_recal.sv */
// Purpose: per-stage proximity detection, calibration hold and forced recalibration
// Assumes: one result per stage per conversion sequence, delivered on CLOCK
// Notes:   every count advances on the owning stage's results, i.e. once per sequence
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module pdr_prox_recal (
  // clock and reset
  input  wire logic                    CLOCK,
  input  wire logic                    RST,
  // apb slave
  input  wire logic                    PSEL,
  input  wire logic                    PENABLE,
  input  wire logic                    PWRITE,
  input  wire logic [11:0]             PADDR,
  input  wire logic [31:0]             PWDATA,
  output logic      [31:0]             PRDATA,
  output logic                         PREADY,
  output logic                         PSLVERR,
  // converter results and contact state
  input  wire pdr_pkg::pdr_result_t    RESULT,
  input  wire logic [7:0]              CONTACT,
  // per-stage status and interrupt
  output logic      [7:0]              PROXIMITY,
  output logic      [7:0]              CAL_ENABLE,
  output logic                         IRQ
);

  // registers
  logic [15:0] hold_skip_r;
  logic [15:0] levels_r;
  logic [15:0] timeouts_r;
  logic [15:0] control_r;
  logic [2:0]  irq_stat_r;
  logic [2:0]  irq_mask_r;
  logic [31:0] rdata_r;

  // per-stage state
  logic [15:0] fast_mem [8][4];
  logic [15:0] slow_mem [8][2];
  logic [15:0] amb_mem  [8];
  logic [15:0] avg_mem  [8];
  logic [3:0]  skip_mem [8];
  logic [7:0]  hold_mem [8];
  logic [9:0]  rc_mem   [8];
  logic [7:0]  init_r;
  logic [7:0]  prox_r;
  logic [7:0]  cal_en_r;

  function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
    absdiff = (a > b) ? (a - b) : (b - a);
  endfunction : absdiff

  // apb decode
  wire        setup_ph = PSEL & ~PENABLE;
  wire        access   = PSEL & PENABLE;
  wire [9:0]  idx      = PADDR[11:2];
  wire        hit_hs   = (idx == pdr_pkg::IDX_HOLD_SKIP);
  wire        hit_lv   = (idx == pdr_pkg::IDX_LEVELS);
  wire        hit_to   = (idx == pdr_pkg::IDX_TIMEOUTS);
  wire        hit_ct   = (idx == pdr_pkg::IDX_CONTROL);
  wire        hit_st   = (idx == pdr_pkg::IDX_STATUS);
  wire        hit_is   = (idx == pdr_pkg::IDX_IRQ_STAT);
  wire        hit_im   = (idx == pdr_pkg::IDX_IRQ_MASK);
  wire        hit_any  = hit_hs | hit_lv | hit_to | hit_ct | hit_st | hit_is | hit_im;
  wire        wr_ok    = access & PWRITE & hit_any;
  wire [31:0] rd_mux   = hit_hs ? {16'h0000, hold_skip_r} :
                         hit_lv ? {16'h0000, levels_r} :
                         hit_to ? {16'h0000, timeouts_r} :
                         hit_ct ? {16'h0000, control_r} :
                         hit_st ? {16'h0000, cal_en_r, prox_r} :
                         hit_is ? {29'h0, irq_stat_r} :
                         hit_im ? {29'h0, irq_mask_r} : 32'h00000000;

  assign PREADY  = 1'b1;
  assign PSLVERR = access & ~hit_any;
  assign PRDATA  = rdata_r;

  // fields
  wire [3:0] skip_cnt   = hold_skip_r[pdr_pkg::SKIP_LSB +: 4];
  wire [3:0] fp_hold    = hold_skip_r[pdr_pkg::FPHOLD_LSB +: 4];
  wire [3:0] lp_hold    = hold_skip_r[pdr_pkg::LPHOLD_LSB +: 4];
  wire [7:0] hover_lvl  = levels_r[pdr_pkg::HOVER_LSB +: 8];
  wire [5:0] appr_lvl   = levels_r[pdr_pkg::APPR_LSB +: 6];
  wire [9:0] fp_tmo     = timeouts_r[pdr_pkg::FPTMO_LSB +: 10];
  wire [5:0] lp_tmo     = timeouts_r[pdr_pkg::LPTMO_LSB +: 6];
  wire       low_power  = control_r[pdr_pkg::LOWPWR_BIT];
  wire [7:0] amb_lvl    = control_r[pdr_pkg::AMBLVL_LSB +: 8];

  // hold length and timeout in sequences, selected by power mode
  wire [7:0] hold_load  = low_power ? {2'b00, lp_hold, 2'b00}
                                    : {fp_hold, 4'h0};
  wire [9:0] tmo_seq    = low_power ? {4'h0, lp_tmo}
                                    : fp_tmo;
  wire [11:0] hover_thr = {hover_lvl, 4'h0};
  wire [9:0]  appr_thr  = {appr_lvl, 4'h0};

  // current stage view
  wire [2:0]  s       = RESULT.stage;
  wire        rv      = RESULT.valid;
  wire [15:0] din     = RESULT.data;
  wire        first   = ~init_r[s];
  wire        push    = rv & (skip_mem[s] == skip_cnt);
  wire [3:0]  skip_nx = push ? 4'h0 : skip_mem[s] + 4'h1;

  wire [15:0] f0 = fast_mem[s][0];
  wire [15:0] f1 = fast_mem[s][1];
  wire [15:0] f2 = fast_mem[s][2];
  wire [17:0] sum4    = {2'b00, din} + {2'b00, f0} + {2'b00, f1} + {2'b00, f2};
  wire [15:0] avg_new = sum4[17:2];
  wire [15:0] avg_use = push ? avg_new : avg_mem[s];
  wire [15:0] amb     = amb_mem[s];

  // comparators work on the FIFO contents after this push
  wire appr_hit  = absdiff(din, f2) > {6'h00, appr_thr};
  wire hover_hit = absdiff(avg_new, amb) > {4'h0, hover_thr};
  wire prox_new  = first ? 1'b0 :
                   push  ? (appr_hit | hover_hit) : prox_r[s];
  wire prox_rise = rv & prox_new & ~prox_r[s];
  wire prox_fall = rv & ~prox_new & prox_r[s];

  // hold countdown; reassertion zeroes it and the fall reloads it
  wire [7:0] hold_cur = hold_mem[s];
  wire [7:0] hold_nx  = prox_new  ? 8'h00 :
                        prox_fall ? hold_load :
                        (hold_cur != 8'h00) ? hold_cur - 8'h01 : 8'h00;
  wire       expire   = rv & ~prox_new & ~prox_fall & (hold_cur == 8'h01);
  wire       cal_ok   = ~prox_new & (hold_nx == 8'h00) & ~CONTACT[s];

  // forced recalibration: positive deviation only
  wire [16:0] amb_hv   = {1'b0, amb} + {5'h00, hover_thr};
  wire        deviate  = ({1'b0, avg_use} > amb_hv);
  wire [9:0]  rc_inc   = rc_mem[s] + 10'h001;
  wire        force_rc = rv & ~first & deviate & (tmo_seq != 10'h000) &
                         (rc_inc >= tmo_seq);
  wire [9:0]  rc_nx    = (~deviate | force_rc) ? 10'h000 : rc_inc;

  // slow filter path; fed at the fast rate since slow skipping lives elsewhere
  wire [15:0] s0_new   = push ? din : slow_mem[s][0];
  wire [15:0] s1_new   = push ? slow_mem[s][0] : slow_mem[s][1];
  wire        sf_gate  = (absdiff(s0_new, s1_new) > {8'h00, amb_lvl}) & ~prox_new;
  wire        amb_upd  = rv & sf_gate & ~prox_new & cal_ok;
  wire [15:0] amb_nx   = first    ? din :
                         force_rc ? avg_use :
                         amb_upd  ? s0_new : amb;

  // interrupt events
  wire [2:0] irq_set;
  assign irq_set[pdr_pkg::IRQ_PROX]   = prox_rise;
  assign irq_set[pdr_pkg::IRQ_RECAL]  = force_rc;
  assign irq_set[pdr_pkg::IRQ_EXPIRE] = expire;
  wire [2:0] irq_clr = (wr_ok & hit_is) ? PWDATA[2:0] : 3'h0;
  wire [2:0] irq_nxt = (irq_stat_r & ~irq_clr) | irq_set;         // set beats clear

  assign PROXIMITY  = prox_r;
  assign CAL_ENABLE = cal_en_r;
  assign IRQ        = |(irq_stat_r & irq_mask_r);

  // register file
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      hold_skip_r <= pdr_pkg::RST_HOLD_SKIP;
      levels_r    <= pdr_pkg::RST_LEVELS;
      timeouts_r  <= pdr_pkg::RST_TIMEOUTS;
      control_r   <= pdr_pkg::RST_CONTROL;
      irq_mask_r  <= pdr_pkg::RST_IRQ;
      irq_stat_r  <= pdr_pkg::RST_IRQ;
      rdata_r     <= 32'h00000000;
    end else begin
      irq_stat_r <= irq_nxt;
      if (setup_ph) begin
        rdata_r <= rd_mux;
      end
      if (wr_ok & hit_hs) begin
        hold_skip_r <= PWDATA[15:0];
      end
      if (wr_ok & hit_lv) begin
        levels_r <= PWDATA[15:0];
      end
      if (wr_ok & hit_to) begin
        timeouts_r <= PWDATA[15:0];
      end
      if (wr_ok & hit_ct) begin
        control_r <= PWDATA[15:0];
      end
      if (wr_ok & hit_im) begin
        irq_mask_r <= PWDATA[2:0];
      end
    end
  end

  // per-stage flags
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      init_r   <= 8'h00;
      prox_r   <= 8'h00;
      cal_en_r <= 8'h00;
    end else if (rv) begin
      init_r[s]   <= 1'b1;
      prox_r[s]   <= prox_new;
      cal_en_r[s] <= cal_ok;
    end
  end

  // per-stage counters and ambient
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < 8; i++) begin
        amb_mem[i]  <= 16'h0000;
        avg_mem[i]  <= 16'h0000;
        skip_mem[i] <= 4'h0;
        hold_mem[i] <= 8'h00;
        rc_mem[i]   <= 10'h000;
      end
    end else if (rv) begin
      amb_mem[s]  <= amb_nx;
      skip_mem[s] <= skip_nx;
      hold_mem[s] <= hold_nx;
      rc_mem[s]   <= rc_nx;
      if (push) begin
        avg_mem[s] <= avg_new;
      end
    end
  end

  // fast and slow FIFOs, entry 0 newest
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < 8; i++) begin
        for (int j = 0; j < 4; j++) begin
          fast_mem[i][j] <= 16'h0000;
        end
        slow_mem[i][0] <= 16'h0000;
        slow_mem[i][1] <= 16'h0000;
      end
    end else if (push) begin
      fast_mem[s][0] <= din;
      fast_mem[s][1] <= f0;
      fast_mem[s][2] <= f1;
      fast_mem[s][3] <= f2;
      slow_mem[s][0] <= s0_new;
      slow_mem[s][1] <= s1_new;
    end
  end

endmodule : pdr_prox_recal

/* File: pdr_prox_recal_props.sv */
// Purpose: port-level assertions for the proximity detect and recalibration block
// Assumes: zero-wait apb slave, PROXIMITY and CAL_ENABLE move only on results
// Notes:   bound from the testbench top file
`timescale 1ns/1ps
module pdr_prox_recal_props (
  // clock and reset
  input wire logic                 CLOCK,
  input wire logic                 RST,
  // apb
  input wire logic                 PSEL,
  input wire logic                 PENABLE,
  input wire logic                 PWRITE,
  input wire logic [11:0]          PADDR,
  input wire logic [31:0]          PWDATA,
  input wire logic [31:0]          PRDATA,
  input wire logic                 PREADY,
  input wire logic                 PSLVERR,
  // results and status
  input wire pdr_pkg::pdr_result_t RESULT,
  input wire logic [7:0]           CONTACT,
  input wire logic [7:0]           PROXIMITY,
  input wire logic [7:0]           CAL_ENABLE,
  input wire logic                 IRQ
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  logic mapped;
  assign mapped = PADDR[11:2] inside {pdr_pkg::IDX_HOLD_SKIP, pdr_pkg::IDX_LEVELS,
    pdr_pkg::IDX_TIMEOUTS, pdr_pkg::IDX_CONTROL, pdr_pkg::IDX_STATUS,
    pdr_pkg::IDX_IRQ_STAT, pdr_pkg::IDX_IRQ_MASK};
  a_ready_always: assert property (PREADY == 1'b1) else $error("pready low");
  a_err_decode: assert property ((PSEL && PENABLE) |-> (PSLVERR == !mapped))
    else $error("pslverr does not match decode");
  a_err_phase: assert property (PSLVERR |-> (PSEL && PENABLE)) else $error("stray pslverr");
  a_upper_zero: assert property (PRDATA[31:16] == 16'h0000) else $error("prdata upper set");
  a_cal_prox: assert property ((PROXIMITY & CAL_ENABLE) == 8'h00)
    else $error("calibration on during proximity");
  a_cal_contact: assert property ((CAL_ENABLE & ~$past(CAL_ENABLE) & $past(CONTACT)) == 8'h00)
    else $error("calibration resumed while touched");
  a_touch_blocks: assert property ((RESULT.valid && CONTACT[RESULT.stage]) |=>
    !CAL_ENABLE[$past(RESULT.stage)]) else $error("calibration allowed while touched");
  a_quiet_idle: assert property (!$past(RESULT.valid) |-> ($stable(PROXIMITY) && $stable(CAL_ENABLE)))
    else $error("status moved without a result");
  a_own_stage: assert property ($past(RESULT.valid) |-> ((((PROXIMITY ^ $past(PROXIMITY))
    | (CAL_ENABLE ^ $past(CAL_ENABLE))) & ~(8'h01 << $past(RESULT.stage))) == 8'h00))
    else $error("status of another stage moved");
endmodule : pdr_prox_recal_props

/* File: testbench.sv */
// Purpose: self-checking bench for proximity detect and recalibration
// Assumes: zero-wait apb slave, converter model drives results
// Notes:   small hold and timeout values keep the run short
`timescale 1ns/1ps
module testbench;
  logic                 clock = 1'b0;
  logic                 rst = 1'b1;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [11:0]          paddr = '0;
  logic [31:0]          pwdata = '0;
  logic [31:0]          prdata, q;
  logic                 pready, pslverr, irq, e;
  logic [7:0]           contact = '0;
  logic [7:0]           proximity, cal_enable;
  pdr_pkg::pdr_result_t result;
  int                   bad_count = 0;
  int                   compares = 0;
  pdr_prox_recal i_dut (.CLOCK(clock), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .RESULT(result), .CONTACT(contact), .PROXIMITY(proximity),
    .CAL_ENABLE(cal_enable), .IRQ(irq));
  pdr_conv_model i_conv (.CLOCK(clock), .RESULT(result));
  initial begin
    forever #2.5 clock = ~clock;
  end
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x) begin
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
      bad_count++;
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb
  task automatic seq(input logic [2:0] s, input logic [15:0] d, input int n);
    repeat (n) i_conv.send(s, d, 0);
  endtask : seq
  task automatic test_regs;
    apb(1'b0, 12'h010, '0);
    chk("timeouts reset", 32'(pdr_pkg::RST_TIMEOUTS), q);
    apb(1'b1, 12'h010, 32'hffff_ffff);
    apb(1'b0, 12'h010, '0);
    chk("timeouts fields", 32'h0000_ffff, q);
    apb(1'b1, 12'h014, 32'hffff_ffff);
    chk("unmapped err", 1'b1, e);
    apb(1'b0, 12'h014, '0);
    chk("unmapped data", 32'h0, q);
    apb(1'b1, 12'h010, '0);
  endtask : test_regs
  // step of 200 codes lifts the average 50 above ambient, approach stays quiet
  task automatic test_hold(input logic [2:0] s, input int n);
    chk("prox idle", 1'b0, proximity[s]);
    seq(s, 16'h04b0, 1);
    chk("prox set", 1'b1, proximity[s]);
    chk("cal stop", 1'b0, cal_enable[s]);
    seq(s, 16'h03e8, 4);
    chk("prox gone", 1'b0, proximity[s]);
    seq(s, 16'h03e8, n - 1);
    chk("cal held", 1'b0, cal_enable[s]);
    @(posedge clock) contact[s] <= 1'b1;
    seq(s, 16'h03e8, 1);
    chk("cal touched", 1'b0, cal_enable[s]);
    @(posedge clock) contact[s] <= 1'b0;
    seq(s, 16'h03e8, 1);
    chk("cal resumed", 1'b1, cal_enable[s]);
  endtask : test_hold
  task automatic test_irq;
    apb(1'b0, 12'h024, '0);
    chk("status reg", 32'h0000_0700, q);
    apb(1'b0, 12'h028, '0);
    chk("irq prox bit", 1'b1, q[0]);
    chk("irq expire bit", 1'b1, q[2]);
    chk("irq masked", 1'b0, irq);
    apb(1'b1, 12'h02c, 32'h1);
    chk("irq raised", 1'b1, irq);
    apb(1'b1, 12'h028, 32'h1);
    chk("irq cleared", 1'b0, irq);
  endtask : test_irq
  // low power timeout 3, full power 9: recalibration must follow the low power field
  task automatic test_recal;
    apb(1'b1, 12'h010, 32'h0000_0c09);
    apb(1'b1, 12'h028, 32'h7);
    seq(3'h2, 16'h0578, 2);
    apb(1'b0, 12'h028, '0);
    chk("recal early", 1'b0, q[1]);
    seq(3'h2, 16'h0578, 1);
    apb(1'b0, 12'h028, '0);
    chk("recal done", 1'b1, q[1]);
  endtask : test_recal
  task automatic wrap_up;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    test_regs();
    for (int s = 0; s < 3; s++) repeat (8) i_conv.send(3'(s), 16'h03e8, 2);
    apb(1'b1, 12'h00c, 32'h0000_3f01);
    apb(1'b1, 12'h008, 32'h0000_0110);
    apb(1'b0, 12'h008, '0);
    chk("hold fields", 32'h0000_0110, q);
    apb(1'b1, 12'h028, 32'h7);
    test_hold(3'h0, 16);
    test_irq();
    apb(1'b1, 12'h020, 32'h1);
    test_hold(3'h1, 4);
    test_recal();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge clock);
    $display("CHECK FAILED watchdog expected finish seen timeout");
    bad_count++;
    wrap_up();
  end
endmodule : testbench
bind pdr_prox_recal pdr_prox_recal_props i_props (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .RESULT(RESULT), .CONTACT(CONTACT),
  .PROXIMITY(PROXIMITY), .CAL_ENABLE(CAL_ENABLE), .IRQ(IRQ));
